// ==== hw/iew_defs.vh ====
// register map, field positions and reset values of the i2c event/wait block
//
// What this block does
// - data phase interrupt and wait land on clock 8 or 9 per wait-timing select
// - wait ends on shift write, wait release, local release, or master start/stop request
// - stop detection interrupts only while stop interrupt enable is set
// - hardware compares received address with own address; match or extension interrupts
// - transmitted bits are read back from the data line into the shift register
// - upper nibble 0000 or 1111 sets extension flag, interrupt at eighth fall
// - ten-bit prefix: nibble match sets extension flag, seven-bit match sets match flag
// - after extension code device takes part; local release returns it to standby
// - arbitration happens when masters request start before start-detected is set
// - losing master sets arbitration-lost flag and releases clock and data lines
// - after loss interrupt at eighth/ninth fall, or at stop if enabled
// - after loss: ninth fall when timing select is 1, else eighth on extension
// - start enters wakeup standby; no interrupts unless own address or extension
// - stop interrupt follows stop enable alone, regardless of wakeup filter
// - unmatched non-extension address gives neither interrupt nor wait
// - master address phase interrupts and waits at ninth fall always
// - a wait holds the clock line low until cancelled
`ifndef IEW_DEFS_VH
`define IEW_DEFS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define IEW_CTRL_OFS 8'h00
`define IEW_STATUS_OFS 8'h04
`define IEW_SHIFT_OFS 8'h08
`define IEW_OWN_ADDR_OFS 8'h0c

// ---------------------------------------------------------------
// serial_control_reg fields
// ---------------------------------------------------------------
`define IEW_CTRL_ENABLE 7
`define IEW_CTRL_LOCAL_RELEASE 6
`define IEW_CTRL_WAIT_RELEASE 5
`define IEW_CTRL_STOP_IRQ_EN 4
`define IEW_CTRL_WAIT_TIMING 3
`define IEW_CTRL_ACK_EN 2
`define IEW_CTRL_START_REQ 1
`define IEW_CTRL_STOP_REQ 0

// ---------------------------------------------------------------
// serial_status_reg fields
// ---------------------------------------------------------------
`define IEW_STAT_MASTER 7
`define IEW_STAT_ARB_LOST 6
`define IEW_STAT_EXT_CODE 5
`define IEW_STAT_ADDR_MATCH 4
`define IEW_STAT_TRANSMIT 3
`define IEW_STAT_ACK_RCVD 2
`define IEW_STAT_START_DET 1
`define IEW_STAT_STOP_DET 0

// ---------------------------------------------------------------
// reset values and byte timing
// ---------------------------------------------------------------
`define IEW_OWN_ADDR_RST 8'h00
`define IEW_SHIFT_RST 8'h00
`define IEW_CLK_EIGHT 4'h8
`define IEW_CLK_NINE 4'h9
`define IEW_NIB_LOW 4'h0
`define IEW_NIB_HIGH 4'hf

`endif

// ==== hw/iew_sync.v ====
// two-flop synchroniser for the bus pins
`timescale 1ns/10ps
`default_nettype none
module iew_sync #(
  parameter WIDTH = 2
) (
  input wire clk_i, // system clock
  input wire rst_n_i, // asynchronous reset, active low
  input wire [WIDTH-1:0] d_i, // asynchronous inputs
  output wire [WIDTH-1:0] q_o // synchronised outputs
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta;
      reg stable;
      // idle bus lines are high, so reset to one
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta <= 1'b1;
          stable <= 1'b1;
        end else begin
          meta <= d_i[g];
          stable <= meta;
        end
      end
      assign q_o[g] = stable;
    end
  endgenerate
endmodule // iew_sync
`default_nettype wire

// ==== hw/iew_core.v ====
// i2c event, wait and arbitration logic with apb register slave
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "iew_defs.vh"
module iew_core (
  input wire clk_i, // system clock, 250 MHz
  input wire rst_n_i, // asynchronous reset, active low
  input wire psel_i, // apb select
  input wire penable_i, // apb enable
  input wire pwrite_i, // apb direction, 1 = write
  input wire [7:0] paddr_i, // apb byte address
  input wire [31:0] pwdata_i, // apb write data
  output reg [31:0] prdata_o, // apb read data
  output reg pready_o, // apb ready
  output reg pslverr_o, // apb error on unmapped address
  input wire serial_clock_pin_i, // clock line level
  output reg serial_clock_pin_o, // clock line drive value, always low
  output reg serial_clock_pin_oe_o, // high while the clock line is held low
  input wire serial_data_pin_i, // data line level
  output reg serial_data_pin_o, // data line drive value, always low
  output reg serial_data_pin_oe_o, // high while the data line is pulled low
  output reg serial_irq_o // one-cycle serial interrupt pulse
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ADDR = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;

  // ---------------------------------------------------------------
  // pin synchronisation and bus event detection
  // ---------------------------------------------------------------
  wire [1:0] pin_s;
  reg scl_q;
  reg sda_q;

  iew_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({serial_clock_pin_i, serial_data_pin_i}),
    .q_o(pin_s)
  );

  wire scl_s = pin_s[1];
  wire sda_s = pin_s[0];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_det = scl_q & scl_s & sda_q & ~sda_s;
  wire stop_det = scl_q & scl_s & ~sda_q & sda_s;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg enable;
  reg stop_irq_enable;
  reg wait_timing_select;
  reg ack_enable;
  reg [7:0] own_address_reg;
  reg [7:0] shift_register;
  reg master;
  reg arb_lost_flag;
  reg ext_code_flag;
  reg address_match_flag;
  reg transmit_flag;
  reg ack_rcvd_flag;
  reg start_detected_flag;
  reg stop_detected_flag;
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg lost_pending;
  reg irq_at_nine;
  reg wait_at_nine;
  reg start_gen;
  reg stop_gen;

  wire [7:0] ctrl_rd = {enable, 2'b00, stop_irq_enable, wait_timing_select,
                        ack_enable, 2'b00};
  wire [7:0] serial_status_reg = {master, arb_lost_flag, ext_code_flag,
                                  address_match_flag, transmit_flag,
                                  ack_rcvd_flag, start_detected_flag,
                                  stop_detected_flag};

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire apb_setup = psel_i & ~penable_i;
  wire apb_done = psel_i & penable_i & pready_o;
  reg hit;
  reg [31:0] rd_data;

  always @* begin
    hit = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr_i == `IEW_CTRL_OFS) begin
      rd_data = {24'h00_0000, ctrl_rd};
    end else if (paddr_i == `IEW_STATUS_OFS) begin
      rd_data = {24'h00_0000, serial_status_reg};
    end else if (paddr_i == `IEW_SHIFT_OFS) begin
      rd_data = {24'h00_0000, shift_register};
    end else if (paddr_i == `IEW_OWN_ADDR_OFS) begin
      rd_data = {24'h00_0000, own_address_reg};
    end else begin
      hit = 1'b0;
    end
  end

  wire wr_ok = apb_done & pwrite_i & hit;
  wire wr_ctrl = wr_ok & (paddr_i == `IEW_CTRL_OFS);
  wire wr_shift = wr_ok & (paddr_i == `IEW_SHIFT_OFS);
  wire wr_own = wr_ok & (paddr_i == `IEW_OWN_ADDR_OFS);
  wire rd_status = apb_done & ~pwrite_i & (paddr_i == `IEW_STATUS_OFS);

  wire local_release = wr_ctrl & pwdata_i[`IEW_CTRL_LOCAL_RELEASE];
  wire wait_release = wr_ctrl & pwdata_i[`IEW_CTRL_WAIT_RELEASE];
  wire start_request = wr_ctrl & pwdata_i[`IEW_CTRL_START_REQ];
  wire stop_request = wr_ctrl & pwdata_i[`IEW_CTRL_STOP_REQ];

  // the device drives data in address phase as master, in data phase per direction
  wire tx_now = state[1] ? master : transmit_flag;
  wire wait_cancel = wr_shift | wait_release | local_release |
                     (master & (start_request | stop_request));

  // address checks on the byte just shifted in
  wire ext_hit = (shift_register[7:4] == `IEW_NIB_LOW) |
                 (shift_register[7:4] == `IEW_NIB_HIGH);
  wire addr_hit = shift_register[7:1] == own_address_reg[7:1];

  // ---------------------------------------------------------------
  // apb response
  // ---------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_setup;
      pslverr_o <= apb_setup & ~hit;
      if (apb_setup) begin
        prdata_o <= rd_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // software-owned registers
  // ---------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable <= 1'b0;
      stop_irq_enable <= 1'b0;
      wait_timing_select <= 1'b0;
      ack_enable <= 1'b0;
      own_address_reg <= `IEW_OWN_ADDR_RST;
    end else begin
      if (wr_ctrl) begin
        enable <= pwdata_i[`IEW_CTRL_ENABLE];
        stop_irq_enable <= pwdata_i[`IEW_CTRL_STOP_IRQ_EN];
        wait_timing_select <= pwdata_i[`IEW_CTRL_WAIT_TIMING];
        ack_enable <= pwdata_i[`IEW_CTRL_ACK_EN];
      end
      if (wr_own) begin
        own_address_reg <= pwdata_i[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // link engine: bit count, events, wait and arbitration
  // ---------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_clock_pin_o <= 1'b0;
      serial_data_pin_o <= 1'b0;
      serial_clock_pin_oe_o <= 1'b0;
      serial_data_pin_oe_o <= 1'b0;
      serial_irq_o <= 1'b0;
      shift_register <= `IEW_SHIFT_RST;
      master <= 1'b0;
      arb_lost_flag <= 1'b0;
      ext_code_flag <= 1'b0;
      address_match_flag <= 1'b0;
      transmit_flag <= 1'b0;
      ack_rcvd_flag <= 1'b0;
      start_detected_flag <= 1'b0;
      stop_detected_flag <= 1'b0;
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      lost_pending <= 1'b0;
      irq_at_nine <= 1'b0;
      wait_at_nine <= 1'b0;
      start_gen <= 1'b0;
      stop_gen <= 1'b0;
    end else if (!enable) begin
      serial_clock_pin_oe_o <= 1'b0;
      serial_data_pin_oe_o <= 1'b0;
      serial_irq_o <= 1'b0;
      master <= 1'b0;
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      lost_pending <= 1'b0;
      irq_at_nine <= 1'b0;
      wait_at_nine <= 1'b0;
      start_gen <= 1'b0;
      stop_gen <= 1'b0;
      start_detected_flag <= 1'b0;
      if (wr_shift) begin
        shift_register <= pwdata_i[7:0];
      end
    end else begin
      serial_irq_o <= 1'b0;
      if (rd_status) begin
        arb_lost_flag <= 1'b0;
      end
      // software side: wait cancel, shift load, start/stop requests
      if (wait_cancel) begin
        serial_clock_pin_oe_o <= 1'b0;
        if (bit_cnt == `IEW_CLK_EIGHT && !tx_now) begin
          serial_data_pin_oe_o <= ack_enable;
        end
      end
      if (wr_shift) begin
        shift_register <= pwdata_i[7:0];
        if (tx_now && bit_cnt == 4'h0) begin
          serial_data_pin_oe_o <= ~pwdata_i[7];
        end
      end
      if (start_request && (!start_detected_flag || master)) begin
        start_gen <= 1'b1;
      end
      if (stop_request && master) begin
        stop_gen <= 1'b1;
      end
      if (local_release) begin
        state <= ST_IDLE;
        ext_code_flag <= 1'b0;
        serial_data_pin_oe_o <= 1'b0;
        irq_at_nine <= 1'b0;
        wait_at_nine <= 1'b0;
      end
      // master line drive for start and stop
      if (start_gen && scl_s && sda_s) begin
        serial_data_pin_oe_o <= 1'b1;
      end
      if (stop_gen && !scl_s) begin
        serial_data_pin_oe_o <= 1'b1;
      end
      if (stop_gen && scl_rise) begin
        serial_data_pin_oe_o <= 1'b0;
        stop_gen <= 1'b0;
      end
      // bus conditions
      if (start_det) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        start_detected_flag <= 1'b1;
        stop_detected_flag <= 1'b0;
        ext_code_flag <= 1'b0;
        address_match_flag <= 1'b0;
        transmit_flag <= 1'b0;
        lost_pending <= 1'b0;
        irq_at_nine <= 1'b0;
        wait_at_nine <= 1'b0;
        master <= start_gen;
        start_gen <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE;
        stop_detected_flag <= 1'b1;
        start_detected_flag <= 1'b0;
        master <= 1'b0;
        lost_pending <= 1'b0;
        serial_clock_pin_oe_o <= 1'b0;
        serial_data_pin_oe_o <= 1'b0;
        serial_irq_o <= stop_irq_enable;
      end else if (scl_rise && !state[0]) begin
        if (bit_cnt < `IEW_CLK_EIGHT) begin
          shift_register <= {shift_register[6:0], sda_s};
          if (master && tx_now && !serial_data_pin_oe_o && !sda_s) begin
            arb_lost_flag <= 1'b1;
            master <= 1'b0;
            lost_pending <= 1'b1;
            serial_clock_pin_oe_o <= 1'b0;
            serial_data_pin_oe_o <= 1'b0;
            start_gen <= 1'b0;
            stop_gen <= 1'b0;
          end
        end else if (bit_cnt == `IEW_CLK_EIGHT && tx_now) begin
          ack_rcvd_flag <= ~sda_s;
        end
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_fall && !state[0]) begin
        if (bit_cnt == 4'h0) begin
          if (master && state[1]) begin
            serial_clock_pin_oe_o <= 1'b1;
          end
        end else if (bit_cnt < `IEW_CLK_EIGHT) begin
          serial_data_pin_oe_o <= tx_now & ~shift_register[7];
        end else if (bit_cnt == `IEW_CLK_EIGHT) begin
          serial_data_pin_oe_o <= 1'b0;
          if (state[1] && master) begin
            transmit_flag <= ~shift_register[0];
            irq_at_nine <= 1'b1;
            wait_at_nine <= 1'b1;
          end else if (state[1] && ext_hit) begin
            ext_code_flag <= 1'b1;
            address_match_flag <= addr_hit;
            transmit_flag <= shift_register[0];
            if (lost_pending && wait_timing_select) begin
              irq_at_nine <= 1'b1;
            end else begin
              serial_irq_o <= 1'b1;
              serial_clock_pin_oe_o <= 1'b1;
              serial_data_pin_oe_o <= ack_enable & wait_timing_select;
            end
          end else if (state[1] && addr_hit) begin
            address_match_flag <= 1'b1;
            transmit_flag <= shift_register[0];
            serial_data_pin_oe_o <= 1'b1;
            irq_at_nine <= 1'b1;
            wait_at_nine <= 1'b1;
          end else if (state[1]) begin
            irq_at_nine <= lost_pending;
          end else if (lost_pending) begin
            if (!wait_timing_select && ext_code_flag) begin
              serial_irq_o <= 1'b1;
            end else begin
              irq_at_nine <= 1'b1;
            end
          end else if (!wait_timing_select) begin
            serial_irq_o <= 1'b1;
            serial_clock_pin_oe_o <= 1'b1;
          end else begin
            irq_at_nine <= 1'b1;
            wait_at_nine <= 1'b1;
            serial_data_pin_oe_o <= ~tx_now & ack_enable;
          end
        end else begin
          bit_cnt <= 4'h0;
          serial_data_pin_oe_o <= 1'b0;
          irq_at_nine <= 1'b0;
          wait_at_nine <= 1'b0;
          serial_irq_o <= irq_at_nine;
          serial_clock_pin_oe_o <= wait_at_nine & ~lost_pending;
          if (lost_pending && !address_match_flag && !ext_code_flag) begin
            state <= ST_IDLE;
          end else if (state[1]) begin
            state <= (master | address_match_flag | ext_code_flag) ? ST_DATA : ST_IDLE;
          end
          if (state[2] && lost_pending) begin
            state <= ST_IDLE;
          end
          if (state[1] && !master && !address_match_flag && !ext_code_flag) begin
            state <= ST_IDLE;
          end
        end
      end
    end
  end

endmodule // iew_core
`default_nettype wire

// ==== sim/iew_core_monitor.sv ====
// port assertions for the i2c event, wait and arbitration block
`timescale 1ns/10ps
`default_nettype none
`include "iew_defs.vh"
module iew_core_monitor (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb address
  input wire logic [31:0] pwdata_i, // apb write data
  input wire logic [31:0] prdata_o, // apb read data
  input wire logic pready_o, // apb ready
  input wire logic pslverr_o, // apb error
  input wire logic serial_clock_pin_i, // clock line
  input wire logic serial_clock_pin_o, // clock drive value
  input wire logic serial_clock_pin_oe_o, // clock hold
  input wire logic serial_data_pin_i, // data line
  input wire logic serial_data_pin_o, // data drive value
  input wire logic serial_data_pin_oe_o, // data pull
  input wire logic serial_irq_o // serial interrupt
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire logic wr_acc = psel_i && penable_i && pready_o && pwrite_i;
  wire logic mapped = paddr_i == `IEW_CTRL_OFS || paddr_i == `IEW_STATUS_OFS ||
    paddr_i == `IEW_SHIFT_OFS || paddr_i == `IEW_OWN_ADDR_OFS;
  logic tm_w;
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) tm_w <= 1'b0;
    else if (wr_acc && paddr_i == `IEW_CTRL_OFS) tm_w <= pwdata_i[`IEW_CTRL_WAIT_TIMING];
  // ----
  // assertions
  // ----
  property p_irq_pulse;
    serial_irq_o |=> !serial_irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
  property p_pins_low;
    !serial_clock_pin_o && !serial_data_pin_o;
  endproperty
  a_pins_low: assert property (p_pins_low) else $error("pin drive value high");
  property p_wait_with_irq;
    $rose(serial_clock_pin_oe_o) |-> serial_irq_o;
  endproperty
  a_wait_with_irq: assert property (p_wait_with_irq) else $error("wait without irq");
  property p_wait_holds;
    serial_clock_pin_oe_o && !wr_acc && !$past(wr_acc) |=> serial_clock_pin_oe_o;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("wait ended by itself");
  property p_cancel_ctrl;
    wr_acc && paddr_i == `IEW_CTRL_OFS && (pwdata_i[5] || pwdata_i[6]) && serial_clock_pin_oe_o
      |-> ##[1:2] !serial_clock_pin_oe_o;
  endproperty
  a_cancel_ctrl: assert property (p_cancel_ctrl) else $error("release kept wait");
  property p_cancel_shift;
    wr_acc && paddr_i == `IEW_SHIFT_OFS && serial_clock_pin_oe_o
      |-> ##[1:2] !serial_clock_pin_oe_o;
  endproperty
  a_cancel_shift: assert property (p_cancel_shift) else $error("shift write kept wait");
  property p_irq_moment;
    serial_irq_o |-> !serial_clock_pin_i || serial_data_pin_i;
  endproperty
  a_irq_moment: assert property (p_irq_moment) else $error("irq off clock low or stop");
  property p_sda_free_in_wait;
    serial_irq_o && serial_clock_pin_oe_o && !tm_w |-> !serial_data_pin_oe_o;
  endproperty
  a_sda_free_in_wait: assert property (p_sda_free_in_wait) else $error("data held in wait");
  property p_ready_shape;
    psel_i && !penable_i |=> pready_o && penable_i;
  endproperty
  a_ready_shape: assert property (p_ready_shape) else $error("apb ready late");
  property p_err_map;
    pready_o |-> pslverr_o == !mapped;
  endproperty
  a_err_map: assert property (p_err_map) else $error("apb error flag wrong");
  c_wait: cover property (serial_irq_o && serial_clock_pin_oe_o);
  c_shift_cancel: cover property (wr_acc && paddr_i == `IEW_SHIFT_OFS && serial_clock_pin_oe_o);
  c_stop_irq: cover property (serial_irq_o && serial_clock_pin_i);
  c_err: cover property (pslverr_o);
endmodule // iew_core_monitor
bind iew_core iew_core_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .serial_clock_pin_i(serial_clock_pin_i), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe_o(serial_clock_pin_oe_o), .serial_data_pin_i(serial_data_pin_i),
  .serial_data_pin_o(serial_data_pin_o), .serial_data_pin_oe_o(serial_data_pin_oe_o),
  .serial_irq_o(serial_irq_o));
`default_nettype wire

// ==== sim/iew_bus_master.sv ====
// behavioural i2c master on the far side of the bus pins
`timescale 1ns/10ps
`default_nettype none
module iew_bus_master (
  input wire logic scl_i, // resolved clock line
  input wire logic sda_i, // resolved data line
  output logic scl_oe_o, // pulls clock low
  output logic sda_oe_o // pulls data low
);
  localparam real HALF = 62.5;
  int falls;
  int stretch_to;
  bit busy;
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    falls = 0;
    stretch_to = 0;
    busy = 1'b0;
  end
  // release clock and wait while a slave stretches it
  task automatic rel_scl();
    int n;
    scl_oe_o = 1'b0;
    n = 0;
    while (scl_i !== 1'b1 && n < 20000) begin
      #4;
      n++;
    end
    if (n >= 20000) stretch_to++;
  endtask
  task automatic start();
    sda_oe_o = 1'b1;
    #(HALF);
    scl_oe_o = 1'b1;
    #(HALF);
  endtask
  // eight bits msb first, then the acknowledge clock
  task automatic send(input logic [7:0] d, output bit ack);
    busy = 1'b1;
    falls = 0;
    for (int i = 8; i >= 0; i--) begin
      sda_oe_o = (i > 0) ? !d[i-1] : 1'b0;
      #(HALF);
      rel_scl();
      if (i == 0) ack = !sda_i;
      #(HALF);
      scl_oe_o = 1'b1;
      falls++;
    end
    busy = 1'b0;
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    #(HALF);
    rel_scl();
    #(HALF);
    sda_oe_o = 1'b0;
    #(HALF);
  endtask
endmodule // iew_bus_master
`default_nettype wire

// ==== sim/i2c_event_wait_arbitration_tb.sv ====
// self-checking bench for the i2c event, wait and arbitration block
`timescale 1ns/10ps
`default_nettype none
`include "iew_defs.vh"
module i2c_event_wait_arbitration_tb;
  logic clk, rst_n, psel, penable, pwrite;
  logic [7:0] paddr, cfg;
  logic [31:0] pwdata, shift_seen;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, m_scl_oe, m_sda_oe;
  wire logic scl = !(scl_oe || m_scl_oe);
  wire logic sda = !(sda_oe || m_sda_oe);
  int bad_count, comparisons, irq_cnt, irq_fall, k;
  logic [7:0] tab_addr [5] = '{8'h84, 8'h86, 8'h00, 8'hf0, 8'hf2};
  logic [7:0] tab_own [5] = '{8'h84, 8'h84, 8'h84, 8'h84, 8'hf2};
  iew_core dut (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .serial_clock_pin_i(scl),
    .serial_clock_pin_o(scl_o), .serial_clock_pin_oe_o(scl_oe), .serial_data_pin_i(sda),
    .serial_data_pin_o(sda_o), .serial_data_pin_oe_o(sda_oe), .serial_irq_o(irq));
  iew_bus_master m (.scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
      irq_fall <= m.falls;
    end
  end
  // ----
  // helpers
  // ----
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic is_ext(input logic [7:0] a);
    return a[7:4] == `IEW_NIB_LOW || a[7:4] == `IEW_NIB_HIGH;
  endfunction
  function automatic logic is_match(input logic [7:0] a, input logic [7:0] own);
    return a[7:1] == own[7:1];
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] v, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("BAD apb ready expected 1 seen %b", pready);
      complete_run();
    end
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, a, d, v, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0, v, e);
  endtask
  // waits for the byte's irq, checks the hold and cancels it
  task automatic serve(input int ef, input bit rx);
    int n, idle, base;
    @(posedge clk);
    base = irq_cnt;
    n = 0;
    idle = 0;
    while (irq_cnt == base && idle < 20 && n < 6000) begin
      @(posedge clk);
      n++;
      if (!m.busy) idle++;
    end
    if (n >= 6000) begin
      bad_count++;
      $display("BAD irq wait expected pulse seen none");
      complete_run();
    end
    repeat (2) @(posedge clk);
    chk("irq fall", ef, (irq_cnt != base) ? irq_fall : 0);
    chk("scl held", 32'(ef != 0), 32'(scl_oe));
    if (ef != 0) begin
      k = rx ? 0 : $urandom % ((ef == 8) ? 3 : 2);
      if (rx) rd(`IEW_SHIFT_OFS, shift_seen);
      if (k == 1) wr(`IEW_SHIFT_OFS, 32'hff);
      else wr(`IEW_CTRL_OFS, {24'h0, cfg | ((k == 0) ? 8'h20 : 8'h40)});
      repeat (2) @(posedge clk);
      chk("scl freed", 0, 32'(scl_oe));
    end
  endtask
  task automatic addr_case(input logic [7:0] own, input logic [7:0] a, input bit tm,
      input bit se);
    logic [7:0] d;
    logic [31:0] v;
    bit ack;
    int c0;
    cfg = 8'h84 | {3'b0, se, tm, 3'b0};
    wr(`IEW_OWN_ADDR_OFS, {24'h0, own});
    wr(`IEW_CTRL_OFS, {24'h0, cfg});
    m.start();
    fork
      m.send(a, ack);
      serve(is_ext(a) ? 8 : (is_match(a, own) ? 9 : 0), 1'b0);
    join
    @(posedge clk);
    if (!is_ext(a)) chk("addr ack", 32'(is_match(a, own)), 32'(ack));
    if (is_ext(a) || is_match(a, own)) begin
      rd(`IEW_STATUS_OFS, v);
      chk("ext flag", 32'(is_ext(a) && k != 2), 32'(v[`IEW_STAT_EXT_CODE]));
      chk("match flag", 32'(is_match(a, own)), 32'(v[`IEW_STAT_ADDR_MATCH]));
      chk("arb lost", 0, 32'(v[`IEW_STAT_ARB_LOST]));
    end
    if (is_match(a, own) && !is_ext(a)) begin
      d = 8'($urandom);
      fork
        m.send(d, ack);
        serve(tm ? 9 : 8, 1'b1);
      join
      @(posedge clk);
      chk("rx data", {24'h0, d}, shift_seen);
      chk("data ack", 1, 32'(ack));
    end
    c0 = irq_cnt;
    m.stop();
    repeat (20) @(posedge clk);
    chk("stop irq", 32'(se), 32'(irq_cnt - c0));
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] v;
    logic e;
    logic [7:0] own, a;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfg = 8'h00;
    rst_n = 1'b0;
    irq_cnt = 0;
    void'($urandom(57101));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`IEW_STATUS_OFS, v);
    chk("status reset", 0, v);
    rd(`IEW_SHIFT_OFS, v);
    chk("shift reset", {24'h0, `IEW_SHIFT_RST}, v);
    rd(`IEW_OWN_ADDR_OFS, v);
    chk("own reset", {24'h0, `IEW_OWN_ADDR_RST}, v);
    apb(1'b1, 8'h10, 32'h5a, v, e);
    chk("unmapped err", 1, 32'(e));
    apb(1'b0, 8'h10, 32'h0, v, e);
    chk("unmapped data", 0, v);
    for (int i = 0; i < 14; i++) begin
      own = (i < 5) ? tab_own[i] : 8'($urandom) & 8'hfe;
      a = (i < 5) ? tab_addr[i] : (($urandom % 2) ? own : 8'($urandom) & 8'hfe);
      addr_case(own, a, 1'($urandom), 1'($urandom));
    end
    chk("stretch timeouts", 0, 32'(m.stretch_to));
    complete_run();
  end
endmodule // i2c_event_wait_arbitration_tb
`default_nettype wire
